//--- gmc_pkg.sv
// Purpose: Constants for the second monitor channel and aux code block
// Assumes: Byte-wide register port, one register per address
// Notes:   Offsets are byte addresses on the plain register port
package gmc_pkg;

    localparam int unsigned GMC_ADDR_W = 8;
    localparam int unsigned GMC_DATA_W = 8;

    // Register offsets
    localparam logic [7:0] GMC_OFS_STATUS = 8'h26;
    localparam logic [7:0] GMC_OFS_RXB    = 8'h27;
    localparam logic [7:0] GMC_OFS_TXB    = 8'h28;
    localparam logic [7:0] GMC_OFS_EVT    = 8'h29;
    localparam logic [7:0] GMC_OFS_CTL    = 8'h2a;
    localparam logic [7:0] GMC_OFS_CIN    = 8'h31;
    localparam logic [7:0] GMC_OFS_COUT   = 8'h32;
    localparam logic [7:0] GMC_OFS_EXIR   = 8'h34;
    localparam logic [7:0] GMC_OFS_EXIM   = 8'h35;

    // Reset values
    localparam logic [7:0] GMC_RST_RXB  = 8'hff;
    localparam logic [7:0] GMC_RST_TXB  = 8'hff;
    localparam logic [3:0] GMC_RST_EVT  = 4'h0;
    localparam logic [3:0] GMC_RST_CTL  = 4'h0;
    localparam logic [5:0] GMC_RST_COUT = 6'h3f;
    localparam logic [7:0] GMC_RST_EXIR = 8'h00;
    localparam logic [7:0] GMC_RST_EXIM = 8'hf7;

    // Event status bits
    localparam int unsigned GMC_EV_DR = 3;
    localparam int unsigned GMC_EV_ER = 2;
    localparam int unsigned GMC_EV_DA = 1;
    localparam int unsigned GMC_EV_AB = 0;

    // Control bits
    localparam int unsigned GMC_CTL_RE = 3;
    localparam int unsigned GMC_CTL_EC = 2;
    localparam int unsigned GMC_CTL_TE = 1;
    localparam int unsigned GMC_CTL_AC = 0;

    // Mode status and extended event bits
    localparam int unsigned GMC_ST_MONITOR_A_TRANSMIT_ACTIVE = 7;
    localparam int unsigned GMC_ST_MONITOR_B_TRANSMIT_ACTIVE = 6;
    localparam int unsigned GMC_EX_M1   = 4;
    localparam int unsigned GMC_EX_M0   = 3;
    localparam int unsigned GMC_EX_CI   = 0;
    localparam logic [7:0]  GMC_EXIM_FIXED = 8'he0;

    // Link frame: 32 bit slots, our field in slots 0..15
    localparam logic [4:0] GMC_LAST_FIELD_BIT = 5'd15;
    localparam logic [4:0] GMC_LAST_FRAME_BIT = 5'd31;
    localparam logic [7:0] GMC_IDLE_BYTE      = 8'hff;
    localparam logic [5:0] GMC_IDLE_CODE      = 6'h3f;

endpackage : gmc_pkg

//--- gmc_ctrl.sv
// What this block does
// - Set active flag drives A bit low
// - Received monitor byte register, resets all ones
// - Transmit monitor byte register, resets all ones
// - Event register, read clears, four low bits
// - Remote acknowledge sets data acknowledged
// - Receive enable gates received and end events
// - E control off: E high, first byte
// - E control on: E driven, every byte
// - Transmit enable gates acknowledge and abort events
// - A control off holds A high
// - Aux code input register, TE mode only
// - Aux code output register, resets all set
// - Channel B change sets extended bit four
// - Channel A change sets extended bit three
// - Aux code change sets bit zero, TE
// - Mask resets F7, fixed bits stay
// - Mask bit one suppresses its event
// - Mode status shows both active flags
//
// Purpose: Register bank and link logic of the second monitor channel
// Assumes: Link clock, frame and data are asynchronous pins
// Notes:   Link edges found by sampling on i_clock
`timescale 1ns/1ps

module gmc_ctrl #(
    parameter int unsigned ABORT_FRAMES = 4
) (
    input  wire logic                          i_clock,
    input  wire logic                          i_resetn,
    input  wire logic [gmc_pkg::GMC_ADDR_W-1:0] i_address,
    input  wire logic [gmc_pkg::GMC_DATA_W-1:0] i_write_data,
    input  wire logic                          i_write_strobe,
    input  wire logic                          i_read_strobe,
    output logic      [gmc_pkg::GMC_DATA_W-1:0] o_read_data,
    input  wire logic                          i_link_clock,
    input  wire logic                          i_link_frame,
    input  wire logic                          i_link_data,
    output logic                               o_link_data,
    input  wire logic                          i_te_mode,
    input  wire logic                          i_monitor_a_transmit_active,
    input  wire logic                          i_monitor_a_change_event
);
    import gmc_pkg::*;

    if (ABORT_FRAMES < 1 || ABORT_FRAMES > 15)
    begin : g_check
        $error("ABORT_FRAMES must lie in 1..15");
    end

    localparam logic [3:0] ABORT_LAST = 4'(ABORT_FRAMES - 1);

    typedef struct packed {
        logic [2:0]  sync1;
        logic [2:0]  sync2;
        logic        clk_prev;
        logic [4:0]  cnt;
        logic [14:0] rxsh;
        logic [15:0] txsh;
        logic        dout;
        logic [7:0]  rx_byte;
        logic [7:0]  tx_byte;
        logic        monitor_b_transmit_active;
        logic [3:0]  wait_cnt;
        logic [3:0]  ev;
        logic [3:0]  ctl;
        logic [5:0]  ci_in;
        logic [5:0]  ci_out;
        logic [7:0]  exir;
        logic        mask_m1;
        logic        mask_ci;
        logic [1:0]  mask_spare;
        logic        rx_a_prev;
        logic        pkt;
        logic        idle;
        logic        e_ack;
        logic [7:0]  rd_data;
    } gmc_state_t;

    localparam gmc_state_t GMC_RESET = '{
        rx_byte:   GMC_RST_RXB,
        tx_byte:   GMC_RST_TXB,
        ev:        GMC_RST_EVT,
        ctl:       GMC_RST_CTL,
        ci_out:    GMC_RST_COUT,
        exir:      GMC_RST_EXIR,
        mask_m1:   GMC_RST_EXIM[GMC_EX_M1],
        mask_ci:   GMC_RST_EXIM[GMC_EX_CI],
        mask_spare: GMC_RST_EXIM[2:1],
        txsh:      16'hffff,
        dout:      1'b1,
        rx_a_prev: 1'b1,
        default:   '0
    };

    gmc_state_t st;
    gmc_state_t next_st;

    logic        rise;
    logic        fall;
    logic        a_bit;
    logic        e_bit;
    logic        frame_done;
    logic [15:0] tx_word;
    logic [15:0] rx_word;
    logic [3:0]  ev_set;
    logic [7:0]  ex_set;
    logic [4:0]  cnt_now;
    logic        rd_hit_evt;
    logic        rd_hit_exir;

    always_comb
    begin
        next_st     = st;
        ev_set      = 4'h0;
        ex_set      = 8'h00;
        frame_done  = 1'b0;
        rx_word     = {st.rxsh, st.sync2[0]};
        rd_hit_evt  = i_read_strobe && (i_address == GMC_OFS_EVT);
        rd_hit_exir = i_read_strobe && (i_address == GMC_OFS_EXIR);

        // Pins pass two flops before anything looks at them
        next_st.sync1    = {i_link_clock, i_link_frame, i_link_data};
        next_st.sync2    = st.sync1;
        next_st.clk_prev = st.sync2[2];
        rise = st.sync2[2] && !st.clk_prev;
        fall = !st.sync2[2] && st.clk_prev;
        cnt_now = st.sync2[1] ? 5'd0 : 5'(st.cnt + 5'd1);

        a_bit = !(st.ctl[GMC_CTL_AC] && st.monitor_b_transmit_active);
        e_bit = !(st.ctl[GMC_CTL_EC] && st.e_ack);
        tx_word = {st.monitor_b_transmit_active ? st.tx_byte : GMC_IDLE_BYTE,
                   i_te_mode ? st.ci_out : GMC_IDLE_CODE,
                   a_bit, e_bit};

        if (rise)
        begin
            next_st.cnt  = cnt_now;
            next_st.rxsh = {st.rxsh[13:0], st.sync2[0]};
            frame_done   = (cnt_now == GMC_LAST_FIELD_BIT);
        end

        // Drive on falling edge so the far end samples a settled bit
        if (fall)
        begin
            if (st.cnt == GMC_LAST_FRAME_BIT)
            begin
                next_st.dout = tx_word[15];
                next_st.txsh = {tx_word[14:0], 1'b1};
            end
            else
            begin
                next_st.dout = st.txsh[15];
                next_st.txsh = {st.txsh[14:0], 1'b1};
            end
        end

        if (frame_done)
        begin
            if (i_te_mode)
            begin
                next_st.ci_in = rx_word[7:2];
                if (rx_word[7:2] != st.ci_in && !st.mask_ci)
                begin
                    ex_set[GMC_EX_CI] = 1'b1;
                end
            end
            // Transmit side: E low from remote is the acknowledge
            if (st.monitor_b_transmit_active && st.ctl[GMC_CTL_AC])
            begin
                if (!rx_word[0])
                begin
                    ev_set[GMC_EV_DA] = st.ctl[GMC_CTL_TE];
                    next_st.monitor_b_transmit_active      = 1'b0;
                    next_st.wait_cnt  = 4'h0;
                end
                else if (st.wait_cnt == ABORT_LAST)
                begin
                    // Remote never answered: give up and report
                    ev_set[GMC_EV_AB] = st.ctl[GMC_CTL_TE];
                    next_st.monitor_b_transmit_active      = 1'b0;
                    next_st.wait_cnt  = 4'h0;
                end
                else
                begin
                    next_st.wait_cnt = 4'(st.wait_cnt + 4'h1);
                end
            end
            // Receive side: A falling marks a new byte, A high twice ends
            next_st.rx_a_prev = rx_word[1];
            next_st.e_ack     = 1'b0;
            if (!rx_word[1] && st.rx_a_prev)
            begin
                next_st.rx_byte = rx_word[15:8];
                next_st.e_ack   = 1'b1;
                next_st.pkt     = 1'b1;
                next_st.idle    = 1'b0;
                ev_set[GMC_EV_DR] = st.ctl[GMC_CTL_RE]
                                    && (st.ctl[GMC_CTL_EC] || !st.pkt);
            end
            else if (rx_word[1] && st.pkt)
            begin
                if (st.idle)
                begin
                    next_st.pkt       = 1'b0;
                    next_st.idle      = 1'b0;
                    ev_set[GMC_EV_ER] = st.ctl[GMC_CTL_RE];
                end
                else
                begin
                    next_st.idle = 1'b1;
                end
            end
            else if (!rx_word[1])
            begin
                next_st.idle = 1'b0;
            end
        end

        ex_set[GMC_EX_M1] = (|ev_set) && !st.mask_m1;
        ex_set[GMC_EX_M0] = i_monitor_a_change_event;

        // New events win over a read-clear in the same cycle
        next_st.ev   = rd_hit_evt  ? ev_set : (st.ev | ev_set);
        next_st.exir = rd_hit_exir ? ex_set : (st.exir | ex_set);

        next_st.rd_data = 8'h00;
        if (i_read_strobe)
        begin
            unique case (i_address)
                GMC_OFS_STATUS: next_st.rd_data = {i_monitor_a_transmit_active,
                                                   st.monitor_b_transmit_active, 6'h00};
                GMC_OFS_RXB:    next_st.rd_data = st.rx_byte;
                GMC_OFS_TXB:    next_st.rd_data = st.tx_byte;
                GMC_OFS_EVT:    next_st.rd_data = {4'h0, st.ev};
                GMC_OFS_CTL:    next_st.rd_data = {4'h0, st.ctl};
                GMC_OFS_CIN:    next_st.rd_data = {2'b00, st.ci_in};
                GMC_OFS_COUT:   next_st.rd_data = {2'b00, st.ci_out};
                GMC_OFS_EXIR:   next_st.rd_data = st.exir;
                GMC_OFS_EXIM:   next_st.rd_data = GMC_EXIM_FIXED
                                    | {3'b000, st.mask_m1, 1'b0, st.mask_spare,
                                       st.mask_ci};
                default:        next_st.rd_data = 8'h00;
            endcase
        end

        if (i_write_strobe)
        begin
            unique case (i_address)
                GMC_OFS_STATUS:
                begin
                    // Only a one starts a transfer; software cannot cancel
                    if (i_write_data[GMC_ST_MONITOR_B_TRANSMIT_ACTIVE])
                    begin
                        next_st.monitor_b_transmit_active     = 1'b1;
                        next_st.wait_cnt = 4'h0;
                    end
                end
                GMC_OFS_TXB:  next_st.tx_byte = i_write_data;
                GMC_OFS_CTL:  next_st.ctl     = i_write_data[3:0];
                GMC_OFS_COUT: next_st.ci_out  = i_write_data[5:0];
                GMC_OFS_EXIM:
                begin
                    next_st.mask_m1 = i_write_data[GMC_EX_M1];
                    next_st.mask_ci = i_write_data[GMC_EX_CI];
                    // Spare bits only hold what was written; only a mask register read returns them
                    next_st.mask_spare = i_write_data[2:1];
                end
                default: next_st.monitor_b_transmit_active = next_st.monitor_b_transmit_active;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st <= GMC_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_read_data = st.rd_data;
    assign o_link_data = st.dout;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);

    property p_a_active;
        frame_done && st.monitor_b_transmit_active && st.ctl[GMC_CTL_AC] |-> !a_bit && !tx_word[1];
    endproperty
    a_a_active: assert property (p_a_active) else $error("A bit not low while active");

    property p_a_idle;
        !st.ctl[GMC_CTL_AC] |-> a_bit;
    endproperty
    a_a_idle: assert property (p_a_idle) else $error("A bit low with A control off");

    property p_evt_clear;
        rd_hit_evt && ev_set == 4'h0 |=> st.ev == 4'h0 ##0 o_read_data == {4'h0, $past(st.ev)};
    endproperty
    a_evt_clear: assert property (p_evt_clear) else $error("Event read did not clear");

    property p_dr_gate;
        ev_set[GMC_EV_DR] |-> st.ctl[GMC_CTL_RE] && (st.ctl[GMC_CTL_EC] || !st.pkt);
    endproperty
    a_dr_gate: assert property (p_dr_gate) else $error("Data received raised when blocked");

    property p_e_high;
        !st.ctl[GMC_CTL_EC] |-> e_bit;
    endproperty
    a_e_high: assert property (p_e_high) else $error("E bit low with E control off");

    property p_tx_gate;
        (ev_set[GMC_EV_DA] || ev_set[GMC_EV_AB]) |-> st.ctl[GMC_CTL_TE] ##1 !st.monitor_b_transmit_active;
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("Transmit event when masked");

    property p_cout_write;
        i_write_strobe && i_address == GMC_OFS_COUT
        |=> st.ci_out == $past(i_write_data[5:0]);
    endproperty
    a_cout_write: assert property (p_cout_write) else $error("Aux code write lost");

    property p_m0_set;
        i_monitor_a_change_event |=> st.exir[GMC_EX_M0];
    endproperty
    a_m0_set: assert property (p_m0_set) else $error("Channel A change not flagged");

    property p_ci_te;
        $rose(st.exir[GMC_EX_CI]) |-> $past(i_te_mode) && !$past(st.mask_ci);
    endproperty
    a_ci_te: assert property (p_ci_te) else $error("Aux change flagged outside TE");

    property p_mask_read;
        i_read_strobe && i_address == GMC_OFS_EXIM
        |=> o_read_data[7:5] == 3'b111 && !o_read_data[3];
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("Fixed mask bits wrong");

    property p_status_read;
        i_read_strobe && i_address == GMC_OFS_STATUS
        |=> o_read_data[GMC_ST_MONITOR_B_TRANSMIT_ACTIVE] == $past(st.monitor_b_transmit_active) && o_read_data[5:0] == 6'h00;
    endproperty
    a_status_read: assert property (p_status_read) else $error("Mode status read wrong");

    property p_a_load;
        fall && st.cnt == GMC_LAST_FRAME_BIT && st.monitor_b_transmit_active && st.ctl[GMC_CTL_AC]
        |=> !st.txsh[2];
    endproperty
    a_a_load: assert property (p_a_load) else $error("A bit not queued low");

    property p_ack_event;
        frame_done && st.monitor_b_transmit_active && st.ctl[GMC_CTL_AC] && st.ctl[GMC_CTL_TE] && !rx_word[0]
        |=> st.ev[GMC_EV_DA];
    endproperty
    a_ack_event: assert property (p_ack_event) else $error("Ack event missing");

    property p_ev_hold;
        !rd_hit_evt |=> (st.ev & $past(st.ev)) == $past(st.ev);
    endproperty
    a_ev_hold: assert property (p_ev_hold) else $error("Event bit lost");

    property p_exir_hold;
        !rd_hit_exir |=> (st.exir & $past(st.exir)) == $past(st.exir);
    endproperty
    a_exir_hold: assert property (p_exir_hold) else $error("Extended event lost");

    c_ack:   cover property (ev_set[GMC_EV_DA]);
    c_m0:    cover property (ex_set[GMC_EX_M0]);
    c_abort: cover property (ev_set[GMC_EV_AB]);
    c_byte:  cover property (ev_set[GMC_EV_DR] ##[1:1000] ev_set[GMC_EV_ER]);
    c_ci:    cover property (ex_set[GMC_EX_CI]);

endmodule // gmc_ctrl

//--- gmc_peer.sv
// Purpose: Far-side peripheral on the serial link, for the bench
// Assumes: 32 slot frame, field in slots 0..15, MSB first
// Notes:   Data line is pulled up, so idle slots read 1
`timescale 1ns/1ps

module gmc_peer (
    output logic            o_link_clock,
    output logic            o_link_frame,
    output logic            o_link_data,
    input  wire logic       i_dev_data,
    input  wire logic [7:0] i_byte,
    input  wire logic [5:0] i_code,
    input  wire logic       i_a,
    input  wire logic       i_e,
    output logic [15:0]     o_seen,
    output int              o_frames
);
    logic [15:0] field;
    logic [15:0] cap;
    int          slot;

    initial
    begin
        o_link_clock = 1'b0;
        o_link_frame = 1'b0;
        o_link_data  = 1'b1;
        o_seen       = 16'hffff;
        o_frames     = 0;
        field        = 16'hffff;
        cap          = 16'hffff;
        slot         = 31;
        #3;
        forever #40 o_link_clock = ~o_link_clock;
    end

    // Latched at slot 0 so one frame never mixes two settings
    always @(negedge o_link_clock)
    begin
        slot = (slot + 1) % 32;
        if (slot == 0)
            field = {i_byte, i_code, i_a, i_e};
        o_link_frame <= (slot == 0);
        o_link_data  <= (slot < 16) ? field[15 - slot] : 1'b1;
    end

    // Device A and E bits land in o_seen[1:0]
    always @(posedge o_link_clock)
    begin
        if (slot < 16)
            cap[15 - slot] <= i_dev_data;
        if (slot == 15)
        begin
            o_seen   <= {cap[15:1], i_dev_data};
            o_frames <= o_frames + 1;
        end
    end
endmodule // gmc_peer

//--- testbench.sv
// Purpose: Self-checking bench for the second monitor channel block
// Assumes: Peer model drives link clock, frame and data
// Notes:   Every frm call returns just after a frame field ends
`timescale 1ns/1ps

module testbench;
    import gmc_pkg::*;
    localparam int AF    = 4;
    localparam int LIMIT = 20000;
    localparam logic [7:0] RADR [9] = '{8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h31, 8'h32,
                                        8'h34, 8'h35};
    localparam logic [7:0] RVAL [9] = '{8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h3f,
                                        8'h00, 8'hf7};
    localparam logic [7:0] WADR [7] = '{8'h28, 8'h2a, 8'h32, 8'h35, 8'h27, 8'h30, 8'h26};
    logic        clk    = 1'b0;
    logic        rstn   = 1'b0;
    logic [7:0]  addr   = 8'h00;
    logic [7:0]  wdata  = 8'h00;
    logic        ws     = 1'b0;
    logic        rs     = 1'b0;
    logic        te     = 1'b0;
    logic        a_act  = 1'b0;
    logic        a_chg  = 1'b0;
    logic [7:0]  p_byte = 8'hff;
    logic [5:0]  p_code = 6'h3f;
    logic        p_a    = 1'b1;
    logic        p_e    = 1'b1;
    logic [7:0]  rdata;
    logic        lclk;
    logic        lfrm;
    logic        ldin;
    logic        ldout;
    logic [15:0] seen;
    int          frames;
    int          fail_count = 0;
    int          n_compared = 0;
    int          cycles     = 0;

    gmc_ctrl #(.ABORT_FRAMES(AF)) i_dut (
        .i_clock                     (clk),
        .i_resetn                    (rstn),
        .i_address                   (addr),
        .i_write_data                (wdata),
        .i_write_strobe              (ws),
        .i_read_strobe               (rs),
        .o_read_data                 (rdata),
        .i_link_clock                (lclk),
        .i_link_frame                (lfrm),
        .i_link_data                 (ldin),
        .o_link_data                 (ldout),
        .i_te_mode                   (te),
        .i_monitor_a_transmit_active (a_act),
        .i_monitor_a_change_event    (a_chg)
    );

    gmc_peer i_peer (
        .o_link_clock (lclk),
        .o_link_frame (lfrm),
        .o_link_data  (ldin),
        .i_dev_data   (ldout),
        .i_byte       (p_byte),
        .i_code       (p_code),
        .i_a          (p_a),
        .i_e          (p_e),
        .o_seen       (seen),
        .o_frames     (frames)
    );

    always #5 clk = ~clk;

    task automatic finish_test;
        $display("Compared %0d, failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Hang guard, well above the expected run length
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            fail_count++;
            finish_test;
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        ws    <= 1'b1;
        @(posedge clk);
        ws <= 1'b0;
    endtask

    task automatic ckr(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] got;
        @(posedge clk);
        addr <= a;
        rs   <= 1'b1;
        @(posedge clk);
        rs <= 1'b0;
        #1;
        got = rdata;
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED reg %h expected %h seen %h", a, exp, got);
        end
    endtask

    task automatic ckl(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // At least one whole frame carries the new values; they stay on the peer until the next call
    task automatic frm(input logic [7:0] b, input logic [5:0] c, input logic a, input logic e);
        int f;
        @(posedge clk);
        p_byte <= b;
        p_code <= c;
        p_a    <= a;
        p_e    <= e;
        f = frames;
        wait (frames != f);
        repeat (10) @(posedge clk);
    endtask

    function automatic logic [7:0] rw_exp(input logic [7:0] a, input logic [7:0] d);
        case (a)
            8'h28:   return d;
            8'h2a:   return d & 8'h0f;
            8'h32:   return d & 8'h3f;
            8'h35:   return (d | 8'he0) & 8'hf7;
            8'h27:   return 8'hff;
            default: return 8'h00;
        endcase
    endfunction

    initial
    begin
        logic [7:0] d;
        logic [5:0] c;
        int         i;
        int         k;
        void'($urandom(23));
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        for (i = 0; i < 9; i++)
            ckr(RADR[i], RVAL[i]);
        for (k = 0; k < 4; k++)
        begin
            d = 8'($urandom);
            for (i = 0; i < 7; i++)
                wr(WADR[i], (WADR[i] == 8'h26) ? (d & 8'hbf) : d);
            for (i = 0; i < 7; i++)
                ckr(WADR[i], rw_exp(WADR[i], d));
        end
        wr(8'h35, 8'he0);
        wr(8'h2a, 8'h00);
        frm(8'hff, 6'h3f, 1'b1, 1'b1);
        for (k = 0; k < 2; k++)
        begin
            te <= k[0];
            d = 8'($urandom);
            c = 6'($urandom_range(63, 1));
            wr(8'h32, d);
            frm(8'hff, c, 1'b1, 1'b1);
            ckl("aux out", k ? (d & 8'h3f) : 8'h3f, {2'b00, seen[7:2]});
            ckr(8'h31, k ? {2'b00, c} : 8'h00);
            ckr(8'h34, k ? 8'h01 : 8'h00);
        end
        c = c ^ 6'h01;
        wr(8'h35, 8'he1);
        ckr(8'h35, 8'he1);
        frm(8'hff, c, 1'b1, 1'b1);
        ckr(8'h31, {2'b00, c});
        ckr(8'h34, 8'h00);
        wr(8'h35, 8'he0);
        d = 8'($urandom);
        wr(8'h28, d);
        wr(8'h2a, 8'h03);
        wr(8'h26, 8'h40);
        ckr(8'h26, 8'h40);
        frm(8'hff, c, 1'b1, 1'b1);
        ckl("tx byte", d, seen[15:8]);
        ckl("A bit", 8'h00, {7'h00, seen[1]});
        frm(8'hff, c, 1'b1, 1'b0);
        ckr(8'h29, 8'h02);
        ckr(8'h29, 8'h00);
        ckr(8'h26, 8'h00);
        ckr(8'h34, 8'h10);
        for (k = 0; k < 2; k++)
        begin
            wr(8'h2a, k ? 8'h01 : 8'h03);
            wr(8'h26, 8'h40);
            for (i = 0; i < AF + 2; i++)
                frm(8'hff, c, 1'b1, 1'b1);
            ckr(8'h29, k ? 8'h00 : 8'h01);
            ckr(8'h26, 8'h00);
            ckr(8'h34, k ? 8'h00 : 8'h10);
        end
        for (k = 0; k < 2; k++)
        begin
            wr(8'h2a, k ? 8'h0c : 8'h08);
            for (i = 0; i < 2; i++)
            begin
                d = 8'($urandom);
                frm(d, c, 1'b1, 1'b1);
                frm(d, c, 1'b0, 1'b1);
                ckr(8'h27, d);
                ckr(8'h29, (i == 0 || k == 1) ? 8'h08 : 8'h00);
                frm(d, c, 1'b0, 1'b1);
                ckl("E bit", k ? 8'h00 : 8'h01, {7'h00, seen[0]});
            end
            frm(8'hff, c, 1'b1, 1'b1);
            frm(8'hff, c, 1'b1, 1'b1);
            ckr(8'h29, 8'h04);
            ckr(8'h34, 8'h10);
        end
        a_act <= 1'b1;
        ckr(8'h26, 8'h80);
        a_act <= 1'b0;
        @(posedge clk);
        addr  <= 8'h34;
        rs    <= 1'b1;
        a_chg <= 1'b1;
        @(posedge clk);
        rs    <= 1'b0;
        a_chg <= 1'b0;
        ckr(8'h34, 8'h08);
        ckr(8'h34, 8'h00);
        wr(8'h2a, 8'h02);
        wr(8'h26, 8'h40);
        frm(8'hff, c, 1'b1, 1'b1);
        ckl("A held", 8'h01, {7'h00, seen[1]});
        finish_test;
    end
endmodule // testbench
